// ===== rtl/fifo_flag_threshold_regs.sv
// Purpose: Shadowed flag threshold registers with update strobe and flag compare
// Assumes: Fill counts are synchronous to pclk; APB master per AMBA 3
// Notes: Zero wait states; unmapped addresses answer with pslverr
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Ch1 empty bytes hold bits 15:8, 7:0
// RULE2: Software zeroes ch0 full high bits 7:6
// RULE3: Keep 22-bit ch0 full threshold
// RULE4: Ch0 full default is 79/80 memory
// RULE5: Ch0 full threshold drives ch0 full flag
// RULE6: Ch0 full from bytes 21:16,15:8,7:0
// RULE7: Software zeroes ch1 full high bits 7:2
// RULE8: 18-bit ch1 full used only dual mode
// RULE9: Ch1 full default is 79/80 ch1 space
// RULE10: Ch1 full from bytes 17:16,15:8,7:0
// RULE11: Software writes zero byte to update register
// RULE12: Changes act only after update write
// RULE13: 18-bit ch1 empty used only dual mode
// RULE14: Shadows copied to working set together
// RULE15: Full flag while count reaches threshold
module fifo_flag_threshold_regs
    import flag_limit_pkg::*;
#(
    parameter int unsigned MEM_WORDS_CH0 = 32'd4194303,
    parameter int unsigned MEM_WORDS_CH1 = 32'd262143,
    parameter bit FRACTION_DEFAULTS = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [FULL0_W-1:0] fill_count_ch0,
    input wire logic [LIMIT1_W-1:0] fill_count_ch1,
    output logic partial_full_flag_ch0,
    output logic partial_full_flag_ch1,
    output logic partial_empty_flag_ch1,
    output logic irq
);

    // Reset values of thresholds; printed registers default to zero
    localparam logic [FULL0_W-1:0] FULL0_INIT = FRACTION_DEFAULTS ?
        FULL0_W'((64'(MEM_WORDS_CH0) * FULL_FRAC_NUM) / FULL_FRAC_DEN) : '0; // RULE4
    localparam logic [LIMIT1_W-1:0] FULL1_INIT = FRACTION_DEFAULTS ?
        LIMIT1_W'((64'(MEM_WORDS_CH1) * FULL_FRAC_NUM) / FULL_FRAC_DEN) : '0; // RULE9

    // Shadow (software visible) storage
    logic [7:0] empty1_high_q;
    logic [7:0] empty1_mid_q;
    logic [7:0] empty1_low_q;
    logic [7:0] full0_high_q;
    logic [7:0] full0_mid_q;
    logic [7:0] full0_low_q;
    logic [7:0] full1_high_q;
    logic [7:0] full1_mid_q;
    logic [7:0] full1_low_q;
    logic [1:0] mode_shadow_q;

    // Working copies that steer the flags
    logic [LIMIT1_W-1:0] empty_limit_ch1_value;
    logic [FULL0_W-1:0] full_limit_ch0_value;
    logic [LIMIT1_W-1:0] full_limit_ch1_value;
    chan_mode_t mode_q;

    logic [INT_W-1:0] int_status_q;
    logic [INT_W-1:0] int_mask_q;
    logic [INT_W-1:0] int_event;

    logic [IDX_W-1:0] idx;
    logic wr_en;
    logic rd_setup;
    logic apply_en;
    logic idx_mapped;
    logic [7:0] wbyte;

    logic full0_d;
    logic full1_d;
    logic empty1_d;

    function automatic logic is_mapped(input logic [IDX_W-1:0] i);
        is_mapped = (i >= IDX_EMPTY_CH1_HIGH && i <= IDX_FULL_CH1_LOW) ||
                    (i >= IDX_CHAN_MODE && i <= IDX_FLAG_STATE) || (i == IDX_APPLY);
    endfunction : is_mapped

    // Write byte masked, only the writable bits kept
    function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
        masked = d & m;
    endfunction : masked

    // Channel 1 flags exist only with two channels
    function automatic logic ch1_enabled(input chan_mode_t m);
        ch1_enabled = (m == MODE_DUAL);
    endfunction : ch1_enabled

    assign idx = paddr[ADDR_W-1:2];
    assign idx_mapped = is_mapped(idx);
    assign wbyte = pwdata[7:0];
    // Byte lane 0 carries all register data
    assign wr_en = psel && penable && pwrite && idx_mapped && pstrb[0];
    assign rd_setup = psel && !penable;
    assign apply_en = wr_en && (idx == IDX_APPLY) && (wbyte == APPLY_CODE); // RULE11
    assign pready = 1'b1;

    // Shadow threshold bytes; each feeds only the working set and the read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty1_high_q <= BYTE_RESET;
        end else if (wr_en && idx == IDX_EMPTY_CH1_HIGH) begin
            empty1_high_q <= masked(wbyte, CH1_HIGH_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty1_mid_q <= BYTE_RESET;
        end else if (wr_en && idx == IDX_EMPTY_CH1_MID) begin
            empty1_mid_q <= wbyte; // RULE1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty1_low_q <= BYTE_RESET;
        end else if (wr_en && idx == IDX_EMPTY_CH1_LOW) begin
            empty1_low_q <= wbyte; // RULE1
        end
    end

    // Reserved bits dropped even if software sets them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full0_high_q <= BYTE_RESET;
        end else if (wr_en && idx == IDX_FULL_CH0_HIGH) begin
            full0_high_q <= masked(wbyte, FULL0_HIGH_MASK); // RULE2
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full0_mid_q <= BYTE_RESET;
        end else if (wr_en && idx == IDX_FULL_CH0_MID) begin
            full0_mid_q <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full0_low_q <= BYTE_RESET;
        end else if (wr_en && idx == IDX_FULL_CH0_LOW) begin
            full0_low_q <= wbyte;
        end
    end

    // Only the two low bits are threshold bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full1_high_q <= BYTE_RESET;
        end else if (wr_en && idx == IDX_FULL_CH1_HIGH) begin
            full1_high_q <= masked(wbyte, CH1_HIGH_MASK); // RULE7
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full1_mid_q <= BYTE_RESET;
        end else if (wr_en && idx == IDX_FULL_CH1_MID) begin
            full1_mid_q <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full1_low_q <= BYTE_RESET;
        end else if (wr_en && idx == IDX_FULL_CH1_LOW) begin
            full1_low_q <= wbyte;
        end
    end

    // Mode shadow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_shadow_q <= MODE_RESET;
        end else if (wr_en && idx == IDX_CHAN_MODE) begin
            mode_shadow_q <= pwdata[1:0];
        end
    end

    // Working set loads all at once, only on the update write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty_limit_ch1_value <= '0;
        end else if (apply_en) begin // RULE12
            empty_limit_ch1_value <= {empty1_high_q[1:0], empty1_mid_q, empty1_low_q}; // RULE14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_limit_ch0_value <= FULL0_INIT;
        end else if (apply_en) begin // RULE12
            full_limit_ch0_value <= {full0_high_q[5:0], full0_mid_q, full0_low_q}; // RULE6
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_limit_ch1_value <= FULL1_INIT;
        end else if (apply_en) begin // RULE12
            full_limit_ch1_value <= {full1_high_q[1:0], full1_mid_q, full1_low_q}; // RULE10
        end
    end

    // Unused code 3 falls back to single channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_SINGLE;
        end else if (apply_en) begin // RULE12
            unique case (mode_shadow_q)
                MODE_DUAL: mode_q <= MODE_DUAL;
                MODE_CASCADE: mode_q <= MODE_CASCADE;
                default: mode_q <= MODE_SINGLE;
            endcase
        end
    end

    // Flag comparison; ch1 limits matter only with two channels
    always_comb begin
        full0_d = (fill_count_ch0 >= full_limit_ch0_value); // RULE3 RULE5 RULE15
        full1_d = ch1_enabled(mode_q) && (fill_count_ch1 >= full_limit_ch1_value); // RULE8 RULE15
        empty1_d = ch1_enabled(mode_q) && (fill_count_ch1 <= empty_limit_ch1_value); // RULE13
    end

    // Registered so a count ripple never glitches a flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            partial_full_flag_ch0 <= 1'b0;
        end else begin
            partial_full_flag_ch0 <= full0_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            partial_full_flag_ch1 <= 1'b0;
        end else begin
            partial_full_flag_ch1 <= full1_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            partial_empty_flag_ch1 <= 1'b0;
        end else begin
            partial_empty_flag_ch1 <= empty1_d;
        end
    end

    // Interrupt events: flag rises and the update taking effect
    always_comb begin
        int_event = '0;
        int_event[INT_FULL0_RISE] = full0_d && !partial_full_flag_ch0;
        int_event[INT_FULL1_RISE] = full1_d && !partial_full_flag_ch1;
        int_event[INT_EMPTY1_RISE] = empty1_d && !partial_empty_flag_ch1;
        int_event[INT_APPLIED] = apply_en;
    end

    // Set beats write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_q <= '0;
        end else begin
            if (wr_en && idx == IDX_INT_STATUS) begin
                int_status_q <= (int_status_q & ~pwdata[INT_W-1:0]) | int_event;
            end else begin
                int_status_q <= int_status_q | int_event;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_q <= '0;
        end else if (wr_en && idx == IDX_INT_MASK) begin
            int_mask_q <= pwdata[INT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status_q & int_mask_q);
        end
    end

    // Error answer only for holes in the map; such an access has no effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            pslverr <= !idx_mapped;
        end
    end

    // Read data captured in setup so the access phase sees a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= '0;
            if (!pwrite) begin
                unique case (idx)
                    IDX_EMPTY_CH1_HIGH: prdata[7:0] <= empty1_high_q;
                    IDX_EMPTY_CH1_MID: prdata[7:0] <= empty1_mid_q;
                    IDX_EMPTY_CH1_LOW: prdata[7:0] <= empty1_low_q;
                    IDX_FULL_CH0_HIGH: prdata[7:0] <= full0_high_q;
                    IDX_FULL_CH0_MID: prdata[7:0] <= full0_mid_q;
                    IDX_FULL_CH0_LOW: prdata[7:0] <= full0_low_q;
                    IDX_FULL_CH1_HIGH: prdata[7:0] <= full1_high_q;
                    IDX_FULL_CH1_MID: prdata[7:0] <= full1_mid_q;
                    IDX_FULL_CH1_LOW: prdata[7:0] <= full1_low_q;
                    IDX_CHAN_MODE: prdata[1:0] <= mode_shadow_q;
                    IDX_INT_STATUS: prdata[INT_W-1:0] <= int_status_q;
                    IDX_INT_MASK: prdata[INT_W-1:0] <= int_mask_q;
                    IDX_FLAG_STATE: prdata[4:0] <= {mode_q, partial_empty_flag_ch1,
                                                    partial_full_flag_ch1, partial_full_flag_ch0};
                    default: prdata <= '0;
                endcase
            end
        end
    end

endmodule : fifo_flag_threshold_regs

`default_nettype wire

// ===== rtl/flag_limit_pkg.sv
// Purpose: Constants for the flag threshold register slice
// Assumes: APB, 32-bit data, one register per aligned word
// Notes: Offsets are register indices; byte address is index times four
package flag_limit_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IDX_W = 6;

    // Register indices
    localparam logic [IDX_W-1:0] IDX_EMPTY_CH1_HIGH = 6'h10;
    localparam logic [IDX_W-1:0] IDX_EMPTY_CH1_MID = 6'h11;
    localparam logic [IDX_W-1:0] IDX_EMPTY_CH1_LOW = 6'h12;
    localparam logic [IDX_W-1:0] IDX_FULL_CH0_HIGH = 6'h13;
    localparam logic [IDX_W-1:0] IDX_FULL_CH0_MID = 6'h14;
    localparam logic [IDX_W-1:0] IDX_FULL_CH0_LOW = 6'h15;
    localparam logic [IDX_W-1:0] IDX_FULL_CH1_HIGH = 6'h16;
    localparam logic [IDX_W-1:0] IDX_FULL_CH1_MID = 6'h17;
    localparam logic [IDX_W-1:0] IDX_FULL_CH1_LOW = 6'h18;
    localparam logic [IDX_W-1:0] IDX_CHAN_MODE = 6'h20;
    localparam logic [IDX_W-1:0] IDX_INT_STATUS = 6'h21;
    localparam logic [IDX_W-1:0] IDX_INT_MASK = 6'h22;
    localparam logic [IDX_W-1:0] IDX_FLAG_STATE = 6'h23;
    localparam logic [IDX_W-1:0] IDX_APPLY = 6'h3f;

    // Threshold widths
    localparam int unsigned FULL0_W = 22;
    localparam int unsigned LIMIT1_W = 18;

    // Writable bits of the high bytes; the rest read as zero
    localparam logic [7:0] FULL0_HIGH_MASK = 8'h3f;
    localparam logic [7:0] CH1_HIGH_MASK = 8'h03;

    // Update register takes effect only on this value
    localparam logic [7:0] APPLY_CODE = 8'h00;

    // Reset values of the byte registers
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Default fraction for full thresholds
    localparam int unsigned FULL_FRAC_NUM = 79;
    localparam int unsigned FULL_FRAC_DEN = 80;

    // Interrupt bit positions
    localparam int unsigned INT_FULL0_RISE = 0;
    localparam int unsigned INT_FULL1_RISE = 1;
    localparam int unsigned INT_EMPTY1_RISE = 2;
    localparam int unsigned INT_APPLIED = 3;
    localparam int unsigned INT_W = 4;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_DUAL = 2'h1,
        MODE_CASCADE = 2'h2
    } chan_mode_t;

    localparam logic [1:0] MODE_RESET = 2'h0;

endpackage : flag_limit_pkg

// ===== testbench/flag_limit_properties.sv
// Purpose: Port-level properties of the flag threshold slice
// Assumes: Default parameters, working thresholds reset to zero
// Notes: Mirrors the ch0 full limit from APB writes
`timescale 1ns/1ps
`default_nettype none
module flag_limit_properties
    import flag_limit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic [FULL0_W-1:0] fill_count_ch0,
    input wire logic [LIMIT1_W-1:0] fill_count_ch1,
    input wire logic partial_full_flag_ch0,
    input wire logic partial_full_flag_ch1,
    input wire logic partial_empty_flag_ch1
);
    logic [5:0] idx;
    logic wr, rd, apply;
    logic [21:0] s0_q, w0_q;
    logic lvl0;
    assign idx = paddr[7:2];
    assign lvl0 = fill_count_ch0 >= w0_q;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign rd = psel && penable && !pwrite;
    assign apply = wr && idx == IDX_APPLY && pwdata[7:0] == APPLY_CODE;
    // Shadow and working copy of the ch0 full limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s0_q <= '0;
            w0_q <= '0;
        end else if (wr && idx == IDX_FULL_CH0_HIGH) s0_q[21:16] <= pwdata[5:0];
        else if (wr && idx == IDX_FULL_CH0_MID) s0_q[15:8] <= pwdata[7:0];
        else if (wr && idx == IDX_FULL_CH0_LOW) s0_q[7:0] <= pwdata[7:0];
        else if (apply) w0_q <= s0_q;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_full0_level: assert property (
        $past(presetn) |-> partial_full_flag_ch0 == $past(lvl0))
        else $error("full0 flag level wrong");
    chk_full0_hold: assert property (
        $past(presetn) && !$past(apply) && $stable(fill_count_ch0) |=> $stable(partial_full_flag_ch0))
        else $error("full0 flag moved without update");
    chk_ch1_hold: assert property (
        $past(presetn) && !$past(apply) && $stable(fill_count_ch1)
        |=> $stable({partial_full_flag_ch1, partial_empty_flag_ch1}))
        else $error("ch1 flags moved without update");
    chk_high0_read: assert property (rd && idx == IDX_FULL_CH0_HIGH |-> prdata == {26'h0, s0_q[21:16]})
        else $error("ch0 high byte read wrong");
    chk_high1_read: assert property (rd && idx == IDX_FULL_CH1_HIGH |-> prdata[31:2] == 30'h0)
        else $error("ch1 high byte spare bits set");
    chk_reset_full: assert property ($rose(presetn) |=> partial_full_flag_ch0)
        else $error("pf0 low after reset");
    chk_zero_wait: assert property (psel |-> pready)
        else $error("pready low");
    chk_apply_read: assert property (rd && idx == IDX_APPLY |-> prdata == 32'h0)
        else $error("update reg reads nonzero");
endmodule : flag_limit_properties
bind fifo_flag_threshold_regs flag_limit_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .fill_count_ch0(fill_count_ch0), .fill_count_ch1(fill_count_ch1),
    .partial_full_flag_ch0(partial_full_flag_ch0), .partial_full_flag_ch1(partial_full_flag_ch1),
    .partial_empty_flag_ch1(partial_empty_flag_ch1));
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the flag threshold slice
// Assumes: Default parameters, zero reset thresholds
// Notes: Rows program all limits and counts; hand tests follow
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import flag_limit_pkg::*;
;
    typedef struct {logic [1:0] m; logic [21:0] t0, c0; logic [17:0] t1, te, c1; logic [2:0] f;} row_t;
    // Fields: mode, ch0 limit, ch0 count, ch1 full, ch1 empty, ch1 count, {pe1,pf1,pf0}
    row_t rows [5] = '{
        '{2'h0, 22'h3abcde, 22'h3abcde, 18'h00000, 18'h3ffff, 18'h00000, 3'h1},
        '{2'h2, 22'h3abcde, 22'h3abcdd, 18'h00000, 18'h3ffff, 18'h00000, 3'h0},
        '{2'h1, 22'h000100, 22'h0000ff, 18'h2a5a5, 18'h10000, 18'h2a5a5, 3'h2},
        '{2'h1, 22'h000000, 22'h000000, 18'h30000, 18'h10000, 18'h10000, 3'h5},
        '{2'h3, 22'h200000, 22'h3fffff, 18'h00000, 18'h3ffff, 18'h00000, 3'h1}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, full0, full1, empty1, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [21:0] fill_count_ch0;
    logic [17:0] fill_count_ch1;
    int num_errors = 0;
    int comparisons = 0;
    fifo_flag_threshold_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fill_count_ch0(fill_count_ch0), .fill_count_ch1(fill_count_ch1),
        .partial_full_flag_ch0(full0), .partial_full_flag_ch1(full1), .partial_empty_flag_ch1(empty1), .irq(irq));
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Whole run needs well under 2000 cycles
    initial begin
        tick(20000);
        num_errors++;
        print_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, fill_count_ch0, fill_count_ch1} <= '0;
        pstrb <= 4'hf;
        tick(10);
        presetn <= 1'b1;
        tick(3);
        check_val("full0 reset", 32'h1, {31'h0, full0});
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, IDX_EMPTY_CH1_HIGH + 6'(i), 8'h00);
            check_val("reset value", 32'h0, rdat);
        end
        foreach (rows[i]) begin
            apb(1'b1, IDX_EMPTY_CH1_HIGH, {6'h00, rows[i].te[17:16]});
            apb(1'b1, IDX_EMPTY_CH1_MID, rows[i].te[15:8]);
            apb(1'b1, IDX_EMPTY_CH1_LOW, rows[i].te[7:0]);
            apb(1'b1, IDX_FULL_CH0_HIGH, {2'h0, rows[i].t0[21:16]});
            apb(1'b1, IDX_FULL_CH0_MID, rows[i].t0[15:8]);
            apb(1'b1, IDX_FULL_CH0_LOW, rows[i].t0[7:0]);
            apb(1'b1, IDX_FULL_CH1_HIGH, {6'h00, rows[i].t1[17:16]});
            apb(1'b1, IDX_FULL_CH1_MID, rows[i].t1[15:8]);
            apb(1'b1, IDX_FULL_CH1_LOW, rows[i].t1[7:0]);
            apb(1'b1, IDX_CHAN_MODE, {6'h00, rows[i].m});
            apb(1'b1, IDX_APPLY, APPLY_CODE);
            fill_count_ch0 <= rows[i].c0;
            fill_count_ch1 <= rows[i].c1;
            tick(3);
            check_val("flags", {29'h0, rows[i].f}, {29'h0, empty1, full1, full0});
            apb(1'b0, IDX_FLAG_STATE, 8'h00);
            check_val("flag state", {27'h0, ((rows[i].m == 2'h3) ? 2'h0 : rows[i].m), rows[i].f}, rdat);
            apb(1'b0, IDX_FULL_CH1_HIGH, 8'h00);
            check_val("ch1 high", {30'h0, rows[i].t1[17:16]}, rdat);
        end
        // Count sits between old and new limit, so only a real update flips pf0
        fill_count_ch0 <= 22'h000030;
        apb(1'b1, IDX_FULL_CH0_HIGH, 8'h00);
        apb(1'b1, IDX_FULL_CH0_MID, 8'h00);
        apb(1'b1, IDX_FULL_CH0_LOW, 8'h20);
        apb(1'b1, IDX_APPLY, 8'h01);
        tick(3);
        check_val("full0 held", 32'h0, {31'h0, full0});
        apb(1'b1, IDX_INT_STATUS, 8'h0f);
        apb(1'b1, IDX_INT_MASK, 8'h01);
        apb(1'b1, IDX_APPLY, APPLY_CODE);
        tick(5);
        check_val("full0 applied", 32'h1, {31'h0, full0});
        check_val("irq raised", 32'h1, {31'h0, irq});
        apb(1'b0, IDX_INT_STATUS, 8'h00);
        check_val("int status", (32'h1 << INT_APPLIED) | (32'h1 << INT_FULL0_RISE), rdat);
        apb(1'b1, IDX_INT_MASK, 8'h00);
        tick(2);
        check_val("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, IDX_INT_STATUS, 8'h0f);
        apb(1'b1, IDX_INT_MASK, 8'h01);
        tick(2);
        check_val("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b0, IDX_APPLY, 8'h00);
        check_val("update reads", 32'h0, rdat);
        check_val("mapped err", 32'h0, {31'h0, err});
        apb(1'b0, 6'h05, 8'h00);
        check_val("unmapped err", 32'h1, {31'h0, err});
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
